// ---- refclk_prbs_port_addr_ctrl.sv ----
// Purpose: Reference choice, output clock divider, pattern test enable and pass, address decode.
// Assumes: All inputs but i_arst_n synchronous to i_clk; byte and oscillator clocks arrive as enable pulses.
// Notes: Per-channel registers are banked by the transaction's channel bit.
`timescale 1ns/1ps
`default_nettype none
module refclk_prbs_port_addr_ctrl (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    // Pins
    input  wire logic        i_reference_choice_pin,
    input  wire logic        i_pattern_test_enable_pin,
    input  wire logic [4:0]  i_port_address_straps,
    input  wire logic        i_channel_a_powerdown_low,
    input  wire logic        i_channel_b_powerdown_low,
    // Clock source enables
    input  wire logic        i_byte_clk_tick_a,
    input  wire logic        i_byte_clk_tick_b,
    input  wire logic        i_osc_div2_tick,
    // Checker results, [ch*5 + lane], lane 4 is high speed side
    input  wire logic [9:0]  i_checker_ok,
    // Management transaction
    input  wire logic [4:0]  i_txn_port_addr,
    input  wire logic [3:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [15:0]      o_rdata,
    output logic             o_rvalid,
    // Reference selection per channel, 1 means reference_input_one
    output logic [1:0]       o_ref_sel,
    // Output clock pairs, enable low means driven
    output logic             o_channel_a_clock_output_p,
    output logic             o_channel_a_clock_output_n,
    output logic             o_channel_a_clock_oe_n,
    output logic             o_channel_b_clock_output_p,
    output logic             o_channel_b_clock_output_n,
    output logic             o_channel_b_clock_oe_n,
    // Pattern test
    output logic [1:0]       o_prbs_enable,
    output logic [5:0]       o_prbs_seq,
    output logic             o_pattern_test_pass_indicator,
    output logic             o_pass_oe_n
);

    ////////////////////////////////////////////////////////////////////////////////
    logic       rst_s1_r;
    logic       rst_n_r;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode.
    logic       hit;
    logic       ch;
    assign hit = (i_txn_port_addr[4:1] == i_port_address_straps[4:1]);
    assign ch  = i_txn_port_addr[0];

    logic [1:0]  ref_sw_r;
    logic [1:0]  clk_src_r;
    logic [1:0]  clk_en_r;
    logic [3:0]  div_code_r [2];
    logic [3:0]  prbs_en_r;
    logic [5:0]  seq_r;
    logic [3:0]  pass_sel_r;
    logic [1:0]  pwr_down_r;
    logic [1:0]  ref_eff;
    logic [1:0]  pd_any;
    logic        pass_live;

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ref_sw_r      <= 2'h0;
            clk_src_r     <= 2'h0;
            clk_en_r      <= 2'h3;
            div_code_r[0] <= refclk_prbs_pkg::DIV_RST;
            div_code_r[1] <= refclk_prbs_pkg::DIV_RST;
            prbs_en_r     <= 4'h0;
            seq_r         <= {refclk_prbs_pkg::SEQ_PRBS31, refclk_prbs_pkg::SEQ_PRBS31};
            pass_sel_r    <= 4'h0;
            pwr_down_r    <= 2'h0;
        end else if (i_wr && hit) begin
            unique case (i_addr)
                refclk_prbs_pkg::ADDR_REF_CTRL:  ref_sw_r[ch] <= i_wdata[0];
                refclk_prbs_pkg::ADDR_CLK_CTRL: begin
                    clk_src_r[ch] <= i_wdata[refclk_prbs_pkg::CLK_SRC_BIT];
                    clk_en_r[ch]  <= i_wdata[refclk_prbs_pkg::CLK_EN_BIT];
                    if (i_wdata[3:0] < refclk_prbs_pkg::DIV_CODES) begin
                        div_code_r[ch] <= i_wdata[3:0];
                    end
                end
                refclk_prbs_pkg::ADDR_PRBS_CTRL: begin
                    prbs_en_r[ch*2 +: 2] <= i_wdata[refclk_prbs_pkg::PRBS_EN_HI:
                                                    refclk_prbs_pkg::PRBS_EN_LO];
                    seq_r[ch*3 +: 3]     <= i_wdata[2:0];
                end
                refclk_prbs_pkg::ADDR_PASS_SEL:  pass_sel_r <= i_wdata[3:0];
                refclk_prbs_pkg::ADDR_PWR_CTRL:  pwr_down_r[ch] <= i_wdata[0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read port; a miss returns no valid so another device may answer.
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_rdata  <= refclk_prbs_pkg::RD_ZERO;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_rd && hit;
            o_rdata  <= refclk_prbs_pkg::RD_ZERO;
            if (i_rd && hit) begin
                unique case (i_addr)
                    refclk_prbs_pkg::ADDR_REF_CTRL:  o_rdata <= {15'h0000, ref_sw_r[ch]};
                    refclk_prbs_pkg::ADDR_CLK_CTRL:  o_rdata <= {10'h000, clk_en_r[ch],
                                                        clk_src_r[ch], div_code_r[ch]};
                    refclk_prbs_pkg::ADDR_PRBS_CTRL: o_rdata <= {2'h0, prbs_en_r[ch*2 +: 2],
                                                        9'h000, seq_r[ch*3 +: 3]};
                    refclk_prbs_pkg::ADDR_PASS_SEL:  o_rdata <= {12'h000, pass_sel_r};
                    refclk_prbs_pkg::ADDR_STATUS:    o_rdata <= {10'h000, pass_live,
                                                        o_prbs_enable, ref_eff[ch],
                                                        i_checker_ok[{3'h0, ch} * 5 + 4],
                                                        pd_any[ch]};
                    refclk_prbs_pkg::ADDR_PWR_CTRL:  o_rdata <= {15'h0000, pwr_down_r[ch]};
                    default: o_rdata <= refclk_prbs_pkg::RD_ZERO;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reference choice: pin high forces reference one, else the register decides.
    assign ref_eff   = {2{i_reference_choice_pin}} | ref_sw_r;
    assign o_ref_sel = ref_eff;

    logic [1:0] pd_pin;
    assign pd_pin = {~i_channel_b_powerdown_low, ~i_channel_a_powerdown_low};
    assign pd_any = pd_pin | pwr_down_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Output clock dividers, one per channel.
    function automatic logic [4:0] ratio_of(input logic [3:0] code);
        unique case (code)
            4'h0: ratio_of = 5'h01;
            4'h1: ratio_of = 5'h02;
            4'h2: ratio_of = 5'h04;
            4'h3: ratio_of = 5'h05;
            4'h4: ratio_of = 5'h08;
            4'h5: ratio_of = 5'h0A;
            4'h6: ratio_of = 5'h10;
            4'h7: ratio_of = 5'h14;
            default: ratio_of = 5'h19;
        endcase
    endfunction : ratio_of

    logic [1:0] clk_lvl;
    logic [1:0] byte_tick;
    assign byte_tick = {i_byte_clk_tick_b, i_byte_clk_tick_a};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_div
            logic       src_tick;
            logic [4:0] cnt_r;
            logic       lvl_r;
            assign src_tick = clk_src_r[g] ? i_osc_div2_tick : byte_tick[g];
            // The level toggles once every ratio source ticks; the ratio counts ticks between toggles.
            always_ff @(posedge i_clk or negedge rst_n_r) begin
                if (!rst_n_r) begin
                    cnt_r <= 5'h00;
                    lvl_r <= 1'b0;
                end else if (src_tick && clk_en_r[g]) begin
                    if (cnt_r + refclk_prbs_pkg::RATIO_ONE >= ratio_of(div_code_r[g])) begin
                        cnt_r <= 5'h00;
                        lvl_r <= ~lvl_r;
                    end else begin
                        cnt_r <= cnt_r + refclk_prbs_pkg::RATIO_ONE;
                    end
                end
            end
            assign clk_lvl[g] = lvl_r & clk_en_r[g];
        end
    endgenerate

    // Reset gives differential zero (p low, n high); power down floats.
    always_comb begin
        o_channel_a_clock_output_p = rst_n_r & clk_lvl[0];
        o_channel_a_clock_output_n = ~(rst_n_r & clk_lvl[0]);
        o_channel_a_clock_oe_n     = rst_n_r & pd_any[0];
        o_channel_b_clock_output_p = rst_n_r & clk_lvl[1];
        o_channel_b_clock_output_n = ~(rst_n_r & clk_lvl[1]);
        o_channel_b_clock_oe_n     = rst_n_r & pd_any[1];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pattern test enables, both sides folded per channel.
    assign o_prbs_enable[0] = i_pattern_test_enable_pin | (|prbs_en_r[1:0]);
    assign o_prbs_enable[1] = i_pattern_test_enable_pin | (|prbs_en_r[3:2]);
    assign o_prbs_seq       = seq_r;

    // Selection: bit 3 channel, bit 2 high speed side, bits 1:0 low speed lane.
    logic [3:0] sel_idx;
    logic       sel_ch;
    assign sel_ch  = pass_sel_r[3];
    assign sel_idx = pass_sel_r[2] ? 4'h4 : {2'h0, pass_sel_r[1:0]};
    assign pass_live = i_checker_ok[{3'h0, sel_ch} * 5 + sel_idx];

    logic pass_r;
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pass_r <= 1'b1;
        end else if (o_prbs_enable[sel_ch]) begin
            pass_r <= pass_live;
        end else begin
            pass_r <= 1'b1;
        end
    end
    // Pass floats only when both channels are pin powered down, driven high in reset.
    assign o_pattern_test_pass_indicator = pass_r | ~rst_n_r;
    assign o_pass_oe_n = rst_n_r & pd_pin[0] & pd_pin[1];

endmodule : refclk_prbs_port_addr_ctrl
`default_nettype wire

// ---- refclk_prbs_pkg.sv ----
// Purpose: Constants for the reference, output clock, pattern test and port address block.
// Assumes: Register map is local to this block, reached over a plain strobe port.
// Notes: Offsets are word indices of the local register port.
package refclk_prbs_pkg;
    localparam logic [3:0] ADDR_REF_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_CLK_CTRL   = 4'h1;
    localparam logic [3:0] ADDR_PRBS_CTRL  = 4'h2;
    localparam logic [3:0] ADDR_PASS_SEL   = 4'h3;
    localparam logic [3:0] ADDR_STATUS     = 4'h4;
    localparam logic [3:0] ADDR_PWR_CTRL   = 4'h5;
    localparam logic [15:0] RD_ZERO        = 16'h0000;
    // Clock control fields.
    localparam int CLK_SRC_BIT             = 4;
    localparam int CLK_EN_BIT              = 5;
    localparam logic [15:0] CLK_CTRL_RST   = 16'h0020;
    // Divider codes, index into the ratio table.
    localparam logic [3:0] DIV_CODES       = 4'h9;
    localparam logic [3:0] DIV_RST         = 4'h0;
    // Pattern control: bits 13:12 per channel enables, 2:0 sequence.
    localparam int PRBS_EN_LO              = 12;
    localparam int PRBS_EN_HI              = 13;
    localparam logic [2:0] SEQ_PRBS31      = 3'h0;
    localparam logic [15:0] PRBS_CTRL_RST  = 16'h0000;
    localparam logic [4:0] RATIO_ONE       = 5'h01;
endpackage : refclk_prbs_pkg

// ---- refclk_prbs_monitor.sv ----
// Purpose: Port assertions for reference, clock, pattern and address logic.
// Assumes: One clock domain; only strap bits 4:1 take part in decode.
// Notes: Floats get two cycles, since the enables may be registered.
`timescale 1ns/1ps
`default_nettype none
module refclk_prbs_monitor (
    input wire logic       i_clk,
    input wire logic       i_arst_n,
    input wire logic       i_reference_choice_pin,
    input wire logic       i_pattern_test_enable_pin,
    input wire logic [4:0] i_port_address_straps,
    input wire logic       i_channel_a_powerdown_low,
    input wire logic       i_channel_b_powerdown_low,
    input wire logic [4:0] i_txn_port_addr,
    input wire logic       i_rd,
    input wire logic       o_rvalid,
    input wire logic [1:0] o_ref_sel,
    input wire logic       o_channel_a_clock_output_p,
    input wire logic       o_channel_a_clock_output_n,
    input wire logic       o_channel_a_clock_oe_n,
    input wire logic [1:0] o_prbs_enable,
    input wire logic       o_pattern_test_pass_indicator,
    input wire logic       o_pass_oe_n
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    wire logic hit = i_txn_port_addr[4:1] == i_port_address_straps[4:1];
    sequence s_rd_hit; i_rd && hit; endsequence
    sequence s_rd_miss; i_rd && !hit; endsequence
    a_ref_pin: assert property (i_reference_choice_pin |-> o_ref_sel == 2'h3)
        else $error("reference pin not honoured");
    a_prbs_or: assert property (i_pattern_test_enable_pin |-> o_prbs_enable == 2'h3)
        else $error("pattern pin not ORed in");
    a_rd_hit: assert property (s_rd_hit |=> o_rvalid)
        else $error("matching read not answered");
    a_rd_miss: assert property (s_rd_miss |=> !o_rvalid)
        else $error("foreign read answered");
    a_rv_pulse: assert property (!i_rd |=> !o_rvalid)
        else $error("answer without read");
    a_pass_idle: assert property ((o_prbs_enable == 2'h0) [*2] |-> o_pattern_test_pass_indicator)
        else $error("pass low while test off");
    a_pass_float: assert property (!(i_channel_a_powerdown_low || i_channel_b_powerdown_low)
        |-> ##[0:2] o_pass_oe_n)
        else $error("pass driven in power down");
    a_clk_float: assert property (!i_channel_a_powerdown_low |-> ##[0:2] o_channel_a_clock_oe_n)
        else $error("clock driven in power down");
    a_clk_diff: assert property (!o_channel_a_clock_oe_n
        |-> o_channel_a_clock_output_p != o_channel_a_clock_output_n)
        else $error("clock pair not differential");
endmodule : refclk_prbs_monitor
bind refclk_prbs_port_addr_ctrl refclk_prbs_monitor mon (.i_clk, .i_arst_n,
    .i_reference_choice_pin, .i_pattern_test_enable_pin, .i_port_address_straps,
    .i_channel_a_powerdown_low, .i_channel_b_powerdown_low, .i_txn_port_addr, .i_rd,
    .o_rvalid, .o_ref_sel, .o_channel_a_clock_output_p, .o_channel_a_clock_output_n,
    .o_channel_a_clock_oe_n, .o_prbs_enable, .o_pattern_test_pass_indicator, .o_pass_oe_n);
`default_nettype wire

// ---- board_model.sv ----
// Purpose: Board side: straps, source clock ticks and checker results.
// Assumes: Ticks every 4 cycles on A, 8 on B, 2 for the oscillator.
// Notes: Checker results follow an error mask set by the bench.
`timescale 1ns/1ps
`default_nettype none
module board_model #(parameter logic [4:0] STRAP = 5'h14) (
    input  wire logic       i_clk,
    input  wire logic [9:0] i_err_mask,
    output logic [4:0]      o_straps,
    output logic            o_tick_a,
    output logic            o_tick_b,
    output logic            o_tick_osc,
    output logic [9:0]      o_checker_ok
);
    logic [2:0] cnt_r = 3'h0;
    always_ff @(posedge i_clk) cnt_r <= cnt_r + 3'h1;
    assign o_straps = {STRAP[4:1], 1'b0};
    assign o_tick_a = cnt_r[1:0] == 2'h0;
    assign o_tick_b = cnt_r == 3'h0;
    assign o_tick_osc = cnt_r[0];
    assign o_checker_ok = ~i_err_mask;
endmodule : board_model
`default_nettype wire

// ---- testbench.sv ----
// Purpose: Self-checking bench for the reference, clock and pattern block.
// Assumes: Byte tick on A every 4 cycles, oscillator tick every 2.
// Notes: Clock periods are timed between rising edges of the A pair.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [4:0] STRAP = 5'h14;
    localparam int RATIO [9] = '{1, 2, 4, 5, 8, 10, 16, 20, 25};
    logic clk = 1'b0, arst_n = 1'b0, ref_pin = 1'b0, prbs_pin = 1'b0;
    logic pd_a_n = 1'b1, pd_b_n = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [3:0] addr = 4'h0, sel;
    logic [4:0] txn = 5'h0, straps;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [9:0] err = 10'h000, ok;
    logic tk_a, tk_b, tk_o, rvalid, ap, an, aoe, pass, poe, bp, bn, boe;
    logic [1:0] ref_sel, prbs_en;
    logic [5:0] seq;
    int n_errors = 0, checked = 0, cycles = 0, seed;
    always #2 clk = ~clk;
    board_model #(.STRAP(STRAP)) board (.i_clk(clk), .i_err_mask(err), .o_straps(straps),
        .o_tick_a(tk_a), .o_tick_b(tk_b), .o_tick_osc(tk_o), .o_checker_ok(ok));
    refclk_prbs_port_addr_ctrl dut (.i_clk(clk), .i_arst_n(arst_n),
        .i_reference_choice_pin(ref_pin), .i_pattern_test_enable_pin(prbs_pin),
        .i_port_address_straps(straps), .i_channel_a_powerdown_low(pd_a_n),
        .i_channel_b_powerdown_low(pd_b_n), .i_byte_clk_tick_a(tk_a), .i_byte_clk_tick_b(tk_b),
        .i_osc_div2_tick(tk_o), .i_checker_ok(ok), .i_txn_port_addr(txn), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_rvalid(rvalid),
        .o_ref_sel(ref_sel), .o_channel_a_clock_output_p(ap), .o_channel_a_clock_output_n(an),
        .o_channel_a_clock_oe_n(aoe), .o_channel_b_clock_output_p(bp),
        .o_channel_b_clock_output_n(bn), .o_channel_b_clock_oe_n(boe), .o_prbs_enable(prbs_en),
        .o_prbs_seq(seq), .o_pattern_test_pass_indicator(pass), .o_pass_oe_n(poe));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // A missed address inverts the upper bits so no strap can match.
    task automatic bus(input logic w, hit, ch, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        txn <= {hit ? STRAP[4:1] : ~STRAP[4:1], ch};
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
    endtask : bus
    task automatic period(input int exp);
        realtime t;
        @(posedge ap);
        @(posedge ap);
        t = $realtime;
        @(posedge ap);
        chk(16'(int'(($realtime - t) / 4.0)), 16'(exp));
    endtask : period
    function automatic logic pass_exp(input logic [3:0] s, input logic [9:0] e);
        return !e[int'(s[3]) * 5 + (s[2] ? 4 : int'(s[1:0]))];
    endfunction : pass_exp
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h127d0ccd;
        repeat (8) @(posedge clk);
        chk({8'h0, pass, poe, ap, an, aoe, bp, bn, boe}, 16'h0092);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({8'h0, seq, ref_sel}, 16'h0000);
        bus(0, 1, 0, refclk_prbs_pkg::ADDR_CLK_CTRL, 16'h0000);
        chk(rdata, refclk_prbs_pkg::CLK_CTRL_RST);
        period(8);
        bus(0, 1, 1, 4'hF, 16'h0000);
        chk(16'(rvalid), 16'h0001);
        chk(rdata, refclk_prbs_pkg::RD_ZERO);
        bus(1, 0, 1, refclk_prbs_pkg::ADDR_REF_CTRL, 16'h0001);
        chk(ref_sel, 2'h0);
        bus(1, 1, 1, refclk_prbs_pkg::ADDR_REF_CTRL, 16'h0001);
        chk(ref_sel, 2'h2);
        ref_pin <= 1'b1;
        @(posedge clk);
        #1;
        chk(ref_sel, 2'h3);
        ref_pin <= 1'b0;
        bus(0, 0, 0, refclk_prbs_pkg::ADDR_CLK_CTRL, 16'h0000);
        chk(rvalid, 1'b0);
        for (int i = 0; i < 10; i++) begin
            bus(1, 1, 0, refclk_prbs_pkg::ADDR_CLK_CTRL, 16'h0030 | 16'(i));
            period(4 * RATIO[i > 8 ? 8 : i]);
        end
        bus(1, 1, 1, refclk_prbs_pkg::ADDR_PRBS_CTRL, 16'h3005);
        chk({prbs_en, seq}, 16'h00A8);
        bus(0, 1, 1, refclk_prbs_pkg::ADDR_STATUS, 16'h0000);
        chk(rdata, 16'h0036);
        bus(1, 1, 1, refclk_prbs_pkg::ADDR_PRBS_CTRL, 16'h0000);
        prbs_pin <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            err <= 10'($random(seed));
            sel = i == 0 ? 4'hC : 4'($random(seed));
            bus(1, 1, 0, refclk_prbs_pkg::ADDR_PASS_SEL, {12'h0, sel});
            repeat (3) @(posedge clk);
            #1;
            chk(pass, pass_exp(sel, err));
        end
        prbs_pin <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(pass, 1'b1);
        pd_a_n <= 1'b0;
        pd_b_n <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk({aoe, boe, poe}, 3'h7);
        pd_a_n <= 1'b1;
        pd_b_n <= 1'b1;
        bus(1, 1, 0, refclk_prbs_pkg::ADDR_PWR_CTRL, 16'h0001);
        repeat (2) @(posedge clk);
        #1;
        chk({aoe, boe, poe}, 3'h4);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
